//--- logic/ptm_pkg.sv
// ptm_pkg: register offsets, field positions and reset values of the timer
// assumes an APB slave with one byte register per aligned 32-bit word
package ptm_pkg;
    // ------------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL0   = 8'h00;
    localparam logic [7:0] OFS_CTRL1   = 8'h04;
    localparam logic [7:0] OFS_CTRL2   = 8'h08;
    localparam logic [7:0] OFS_CNT_LO  = 8'h0C;
    localparam logic [7:0] OFS_CNT_HI  = 8'h10;
    localparam logic [7:0] OFS_CMPA_LO = 8'h14;
    localparam logic [7:0] OFS_CMPA_HI = 8'h18;
    localparam logic [7:0] OFS_CAPB_LO = 8'h1C;
    localparam logic [7:0] OFS_CAPB_HI = 8'h20;
    localparam logic [7:0] OFS_PER_LO  = 8'h24;
    localparam logic [7:0] OFS_PER_HI  = 8'h28;
    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int BIT_ENABLE   = 3;
    localparam int BIT_FSEL     = 0;
    localparam int BIT_MODE     = 6;
    localparam int BIT_PIN      = 4;
    localparam int BIT_OLVL     = 3;
    localparam int BIT_INV      = 2;
    localparam int BIT_CSRC     = 1;
    localparam int BIT_CCLR     = 0;
    localparam int BIT_TCLR     = 1;
    localparam int BIT_VLF      = 0;
    // ------------------------------------------------------------------
    // reset values and codes
    // ------------------------------------------------------------------
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [15:0] CNT_MAX  = 16'hFFFF;
    localparam logic [1:0] MODE_CMP  = 2'h0;
    localparam logic [1:0] MODE_CAP  = 2'h1;
    localparam logic [1:0] MODE_PWM  = 2'h2;
    localparam logic [1:0] MODE_TMR  = 2'h3;
    localparam logic [1:0] PA_0      = 2'h0;
    localparam logic [1:0] PA_1      = 2'h1;
    localparam logic [1:0] PA_2      = 2'h2;
    localparam logic [1:0] PA_3      = 2'h3;
endpackage

//--- logic/ptm_timer.sv
// ptm_timer: periodic timer unit zero with APB byte registers
// assumes counter clock equals clk; pins come from outside and are synced
//
// Functional notes
// [R1] capture codes pick A edge, tclr zero
// [R2] tclr nonzero: codes route edges A/B
// [R3] A match: keep, low, high, toggle pin
// [R4] matching initial level gives no change
// [R5] enable rise restores initial pin level
// [R6] pwm codes: inactive, active, pwm, pulse
// [R7] software changes pin codes only when off
// [R8] mode field picks four operating modes
// [R9] software switches off before mode changes
// [R10] timer mode ignores pin control bits
// [R11] level bit: initial level, pwm polarity
// [R12] level bit sets pulse start level
// [R13] invert bit flips output pin
// [R14] capture source pin or filtered choice
// [R15] clear on A match or P/overflow
// [R16] overflow clear only with period zero
// [R17] clear select ignored outside compare/timer
// [R18] edge clear selection in capture mode
// [R19] flag reports edge of last latch
// [R20] second capture register, sixteen bits
// [R21] counter readable as byte pair
// [R22] compare A register byte pair
// [R23] enable rise zeroes counter, fall holds
// [R24] low byte buffered, high read latches
// [R25] capture edges synchronised before detection
// [R26] match flags set with their event
`timescale 1ns/100ps
module ptm_timer (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        capture_input_pin,
    input  wire logic        external_clock_pin,
    input  wire logic        filter_data_in,
    output logic             timer_output_pin,
    output logic             match_a_flag,
    output logic             match_p_flag
);
    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [7:0]  ctrl0_q, ctrl1_q;
    logic [1:0]  tclr_q;
    logic        vlf_q;
    logic [15:0] cnt_q, cmpa_q, capb_q, per_q;
    logic [7:0]  wbuf_q, rbuf_q;
    logic        pin_q, en_d1_q;
    logic [1:0]  cap_sync_q, clk_sync_q, flt_sync_q;
    logic        src_d1_q;
    logic        pslverr_q;
    logic        cap_src, rise, fall;

    logic [1:0]  mode, pact;
    logic        en, olvl, inv, csrc, cclr, fsel;
    assign mode = ctrl1_q[ptm_pkg::BIT_MODE +: 2];
    assign pact = ctrl1_q[ptm_pkg::BIT_PIN +: 2];
    assign olvl = ctrl1_q[ptm_pkg::BIT_OLVL];
    assign inv  = ctrl1_q[ptm_pkg::BIT_INV];
    assign csrc = ctrl1_q[ptm_pkg::BIT_CSRC];
    assign cclr = ctrl1_q[ptm_pkg::BIT_CCLR];
    assign en   = ctrl0_q[ptm_pkg::BIT_ENABLE];
    assign fsel = ctrl0_q[ptm_pkg::BIT_FSEL];

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    logic acc, wr, rd;
    assign acc = psel && penable;
    assign wr  = acc && pwrite;
    assign rd  = acc && !pwrite;
    logic [7:0] wb;
    assign wb = pwdata[7:0];
    logic mapped;
    always_comb begin
        case (paddr)
            ptm_pkg::OFS_CTRL0, ptm_pkg::OFS_CTRL1, ptm_pkg::OFS_CTRL2,
            ptm_pkg::OFS_CNT_LO, ptm_pkg::OFS_CNT_HI,
            ptm_pkg::OFS_CMPA_LO, ptm_pkg::OFS_CMPA_HI,
            ptm_pkg::OFS_CAPB_LO, ptm_pkg::OFS_CAPB_HI,
            ptm_pkg::OFS_PER_LO, ptm_pkg::OFS_PER_HI: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    logic wr_ctrl0, wr_ctrl1, wr_ctrl2;
    logic wr_ahi, wr_bhi, wr_phi;
    assign wr_ctrl0 = wr && paddr == ptm_pkg::OFS_CTRL0;
    assign wr_ctrl1 = wr && paddr == ptm_pkg::OFS_CTRL1;
    assign wr_ctrl2 = wr && paddr == ptm_pkg::OFS_CTRL2;
    assign wr_ahi   = wr && paddr == ptm_pkg::OFS_CMPA_HI;
    assign wr_bhi   = wr && paddr == ptm_pkg::OFS_CAPB_HI;
    assign wr_phi   = wr && paddr == ptm_pkg::OFS_PER_HI;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    // [R25] two-stage sync of pins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cap_sync_q <= 2'h0;
            clk_sync_q <= 2'h0;
            flt_sync_q <= 2'h0;
            src_d1_q   <= 1'b0;
        end else begin
            cap_sync_q <= {cap_sync_q[0], capture_input_pin};
            clk_sync_q <= {clk_sync_q[0], external_clock_pin};
            flt_sync_q <= {flt_sync_q[0], filter_data_in};
            src_d1_q   <= cap_src;
        end
    end
    // [R14] trigger source choice
    assign cap_src = !csrc ? cap_sync_q[1] :
                     (fsel ? flt_sync_q[1] : clk_sync_q[1]);
    assign rise = cap_src && !src_d1_q;
    assign fall = !cap_src && src_d1_q;

    // ------------------------------------------------------------------
    // compare, capture and clear
    // ------------------------------------------------------------------
    logic run, en_rise, cmp_like, match_a, match_p, ovf;
    assign en_rise  = en && !en_d1_q;
    assign run      = en && !en_rise;
    assign cmp_like = (mode == ptm_pkg::MODE_CMP) ||
                      (mode == ptm_pkg::MODE_TMR);
    assign match_a  = run && cnt_q == cmpa_q && cmpa_q != ptm_pkg::RST_WORD;
    assign match_p  = run && cnt_q == per_q && per_q != ptm_pkg::RST_WORD;
    // [R16] overflow only when period zero
    assign ovf = run && cnt_q == ptm_pkg::CNT_MAX &&
                 per_q == ptm_pkg::RST_WORD;

    logic cap_a, cap_b, cap_mode, edge_clr;
    assign cap_mode = mode == ptm_pkg::MODE_CAP;
    always_comb begin
        cap_a = 1'b0;
        cap_b = 1'b0;
        if (cap_mode && en) begin
            if (tclr_q == 2'h0) begin
                // [R1] single register capture
                case (pact)
                    ptm_pkg::PA_0: cap_a = rise;
                    ptm_pkg::PA_1: cap_a = fall;
                    ptm_pkg::PA_2: cap_a = rise || fall;
                    default:       cap_a = 1'b0;
                endcase
            end else begin
                // [R2] edge routed to A or B
                case (pact)
                    ptm_pkg::PA_0: cap_b = rise;
                    ptm_pkg::PA_1: cap_a = fall;
                    ptm_pkg::PA_2: begin
                        cap_a = fall;
                        cap_b = rise;
                    end
                    default: cap_a = 1'b0;
                endcase
            end
        end
    end
    // [R18] edge clear in capture mode
    always_comb begin
        case (tclr_q)
            2'h1:    edge_clr = rise;
            2'h2:    edge_clr = fall;
            2'h3:    edge_clr = rise || fall;
            default: edge_clr = 1'b0;
        endcase
        edge_clr = edge_clr && cap_mode && run;
    end

    logic clr;
    logic single;
    assign single = mode == ptm_pkg::MODE_PWM && pact == ptm_pkg::PA_3;
    always_comb begin
        // [R15] clear source in compare/timer
        if (cmp_like)
            clr = cclr ? match_a : (match_p || ovf);
        else if (single)
            clr = 1'b0;
        else
            // [R17] select bit unused here
            clr = match_p || edge_clr;
    end

    // [R23] counter zeroed on enable rise
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            cnt_q <= ptm_pkg::RST_WORD;
        else if (en_rise || clr)
            cnt_q <= ptm_pkg::RST_WORD;
        else if (run)
            cnt_q <= cnt_q + 16'h0001;
    end

    // [R26] flags with their events
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            match_a_flag <= 1'b0;
            match_p_flag <= 1'b0;
        end else begin
            match_a_flag <= cap_mode ? cap_a : match_a;
            match_p_flag <= match_p && !(cmp_like && cclr) && !single;
        end
    end

    // ------------------------------------------------------------------
    // registers written by software
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl0_q <= ptm_pkg::RST_BYTE;
            ctrl1_q <= ptm_pkg::RST_BYTE;
            tclr_q  <= 2'h0;
            en_d1_q <= 1'b0;
        end else begin
            en_d1_q <= en;
            // [R8] mode and pin fields
            if (wr_ctrl1)
                ctrl1_q <= wb;
            if (wr_ctrl2)
                tclr_q <= wb[ptm_pkg::BIT_TCLR +: 2];
            if (wr_ctrl0)
                ctrl0_q <= wb & 8'hF9;
            else if (single && match_a)
                ctrl0_q[ptm_pkg::BIT_ENABLE] <= 1'b0;
        end
    end

    // [R24] low byte write buffer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            wbuf_q <= ptm_pkg::RST_BYTE;
        else if (wr && (paddr == ptm_pkg::OFS_CMPA_LO ||
                        paddr == ptm_pkg::OFS_CAPB_LO ||
                        paddr == ptm_pkg::OFS_PER_LO))
            wbuf_q <= wb;
    end

    // [R22] compare A pair, [R20] B pair, captures win
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cmpa_q <= ptm_pkg::RST_WORD;
            capb_q <= ptm_pkg::RST_WORD;
            per_q  <= ptm_pkg::RST_WORD;
            vlf_q  <= 1'b0;
        end else begin
            if (cap_a)
                cmpa_q <= cnt_q;
            else if (wr_ahi)
                cmpa_q <= {wb, wbuf_q};
            if (cap_b)
                capb_q <= cnt_q;
            else if (wr_bhi)
                capb_q <= {wb, wbuf_q};
            if (wr_phi)
                per_q <= {wb, wbuf_q};
            // [R19] latch edge flag
            if (cap_a || cap_b)
                vlf_q <= rise;
        end
    end

    // ------------------------------------------------------------------
    // output pin
    // ------------------------------------------------------------------
    logic pwm_lvl;
    assign pwm_lvl = (cnt_q < cmpa_q) || (cmpa_q >= per_q &&
                     per_q != ptm_pkg::RST_WORD) ? olvl : !olvl;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            pin_q <= 1'b0;
        else if (mode == ptm_pkg::MODE_CMP) begin
            if (en_rise)
                // [R5] restore initial level
                pin_q <= olvl;
            else if (match_a) begin
                // [R3] action on A match
                // [R4] same level means no change
                case (pact)
                    ptm_pkg::PA_1: pin_q <= 1'b0;
                    ptm_pkg::PA_2: pin_q <= 1'b1;
                    ptm_pkg::PA_3: pin_q <= !pin_q;
                    default:       pin_q <= pin_q;
                endcase
            end
        end else if (mode == ptm_pkg::MODE_PWM) begin
            // [R6] pwm pin codes, [R11] polarity
            case (pact)
                ptm_pkg::PA_0: pin_q <= !olvl;
                ptm_pkg::PA_1: pin_q <= olvl;
                ptm_pkg::PA_2: pin_q <= en ? pwm_lvl : !olvl;
                // [R12] pulse starts at level bit
                default:       pin_q <= (en && !match_a) ? olvl : !olvl;
            endcase
        end
        // [R10] timer and capture modes hold the pin
    end
    // [R13] invert stage, registered
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            timer_output_pin <= 1'b0;
        else if (mode != ptm_pkg::MODE_TMR)
            timer_output_pin <= pin_q ^ inv;
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    logic [7:0] rbyte;
    always_comb begin
        case (paddr)
            ptm_pkg::OFS_CTRL0:   rbyte = ctrl0_q;
            ptm_pkg::OFS_CTRL1:   rbyte = ctrl1_q;
            ptm_pkg::OFS_CTRL2:   rbyte = {5'h00, tclr_q, vlf_q};
            // [R21] counter byte pair
            ptm_pkg::OFS_CNT_HI:  rbyte = cnt_q[15:8];
            ptm_pkg::OFS_CMPA_HI: rbyte = cmpa_q[15:8];
            ptm_pkg::OFS_CAPB_HI: rbyte = capb_q[15:8];
            ptm_pkg::OFS_PER_HI:  rbyte = per_q[15:8];
            ptm_pkg::OFS_CNT_LO, ptm_pkg::OFS_CMPA_LO,
            ptm_pkg::OFS_CAPB_LO, ptm_pkg::OFS_PER_LO: rbyte = rbuf_q;
            default:              rbyte = ptm_pkg::RST_BYTE;
        endcase
    end
    // [R24] high read latches low byte
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            rbuf_q <= ptm_pkg::RST_BYTE;
        else if (rd) begin
            case (paddr)
                ptm_pkg::OFS_CNT_HI:  rbuf_q <= cnt_q[7:0];
                ptm_pkg::OFS_CMPA_HI: rbuf_q <= cmpa_q[7:0];
                ptm_pkg::OFS_CAPB_HI: rbuf_q <= capb_q[7:0];
                ptm_pkg::OFS_PER_HI:  rbuf_q <= per_q[7:0];
                default:              rbuf_q <= rbuf_q;
            endcase
        end
    end
    // no wait state: answer registered in setup, pready in access
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata    <= 32'h0000_0000;
            pready    <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready    <= psel && !penable;
            pslverr_q <= psel && !penable && !mapped;
            if (psel && !penable && !pwrite)
                prdata <= {24'h000000, rbyte};
        end
    end
    assign pslverr = pslverr_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence en_up_s;
        en && !en_d1_q;
    endsequence
    cnt_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
        en_up_s |=> cnt_q == 16'h0000) // [R23]
        else $error("counter not zeroed after enable rise");
    hold_off_a: assert property (@(posedge clk) disable iff (!reset_n)
        !en && !en_d1_q |=> $stable(cnt_q)) // [R23]
        else $error("counter moved while off");
    init_lvl_a: assert property (@(posedge clk) disable iff (!reset_n)
        en_up_s ##0 mode == 2'h0 |=> pin_q == $past(olvl)) // [R5]
        else $error("pin not at initial level");
    toggle_a: assert property (@(posedge clk) disable iff (!reset_n)
        match_a && !en_rise && mode == 2'h0 && pact == 2'h3
        |=> pin_q != $past(pin_q)) // [R3]
        else $error("toggle missing");
    ovf_clr_a: assert property (@(posedge clk) disable iff (!reset_n)
        ovf && cmp_like && !cclr |=> cnt_q == 16'h0000) // [R16]
        else $error("overflow did not clear");
    cap_a_a: assert property (@(posedge clk) disable iff (!reset_n)
        cap_a |=> cmpa_q == $past(cnt_q)) // [R1]
        else $error("capture A value wrong");
    cap_b_a: assert property (@(posedge clk) disable iff (!reset_n)
        cap_b |=> capb_q == $past(cnt_q) && vlf_q) // [R2]
        else $error("capture B value or flag wrong");
    flag_a_a: assert property (@(posedge clk) disable iff (!reset_n)
        match_a && !cap_mode |=> match_a_flag) // [R26]
        else $error("A flag missing");
    hi_write_a: assert property (@(posedge clk) disable iff (!reset_n)
        wr_phi |=> per_q == {$past(wb), $past(wbuf_q)}) // [R24]
        else $error("period pair write wrong");
    inv_a: assert property (@(posedge clk) disable iff (!reset_n)
        mode == 2'h0 ##1 mode == 2'h0
        |-> timer_output_pin == ($past(pin_q) ^ $past(inv))) // [R13]
        else $error("output inversion wrong");
endmodule

//--- tb/periodic_timer_mode_control_test.sv
// periodic_timer_mode_control_test: register, pin and capture checks
// assumes ptm_timer with zero-wait APB and the pin model on its far side
`timescale 1ns/100ps
module periodic_timer_mode_control_test;
    logic        clk;
    logic        reset_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cap;
    logic        ext;
    logic        flt;
    logic        pin;
    logic        fa;
    logic        fp;
    int          err_count;
    int          checks;
    int          na;
    int          np;
    logic [7:0]  rq;
    logic        serr;
    logic [1:0]  ps;

    ptm_timer i_ptm_timer (.clk(clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .capture_input_pin(cap), .external_clock_pin(ext),
        .filter_data_in(flt), .timer_output_pin(pin),
        .match_a_flag(fa), .match_p_flag(fp));
    ptm_pin_model i_ptm_pin_model (.clk(clk), .cap_pin(cap), .ext_pin(ext),
        .flt_pin(flt));

    // ------------------------------------------------------------------
    // clock, flag counters, bus tasks
    // ------------------------------------------------------------------
    always #50 clk = ~clk;

    always @(posedge clk) begin
        if (fa === 1'b1) na = na + 1;
        if (fp === 1'b1) np = np + 1;
    end

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // no local limit: only the watchdog ends a wait
        while (pready !== 1'b1)
            @(posedge clk);
        rq = prdata[7:0];
        serr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // high byte read first so the low byte comes from the same snapshot
    task automatic rd16(input logic [7:0] hi, output logic [15:0] v);
        apb(1'b0, hi, 8'h00);
        v[15:8] = rq;
        apb(1'b0, hi - 8'h04, 8'h00);
        v[7:0] = rq;
    endtask

    task automatic wr16(input logic [7:0] hi, input logic [15:0] v);
        apb(1'b1, hi - 8'h04, v[7:0]);
        apb(1'b1, hi, v[15:8]);
    endtask

    task automatic chk(input string nm, input logic [15:0] lo,
                       input logic [15:0] hi, input logic [15:0] got);
        checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            err_count++;
            $display("[FAIL] %s expected %h..%h seen %h", nm, lo, hi, got);
        end
    endtask

    // timer is always stopped before its mode or pin bits change
    task automatic run(input logic [7:0] c1v);
        apb(1'b1, ptm_pkg::OFS_CTRL0, 8'h00); // stop first
        apb(1'b1, ptm_pkg::OFS_CTRL1, c1v);
        na = 0;
        np = 0;
        apb(1'b1, ptm_pkg::OFS_CTRL0, 8'h08);
    endtask

    function automatic logic [7:0] c1(logic [1:0] m, logic [1:0] p,
        logic o, logic i, logic s, logic c);
        return {m, p, o, i, s, c};
    endfunction

    task automatic test_done();
        if (err_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------------
    initial begin
        logic        o;
        logic        e;
        logic        pv;
        logic [1:0]  code;
        logic [15:0] v;
        int          h;
        {clk, reset_n, psel, penable, pwrite} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        err_count = 0;
        checks = 0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        for (int a = 0; a <= 32; a += 4) begin
            apb(1'b0, a[7:0], 8'h00);
            chk("reset value", 0, 0, rq);
        end
        apb(1'b0, 8'h40, 8'h00);
        chk("unmapped err", 1, 1, serr);
        chk("unmapped data", 0, 0, rq);
        wr16(ptm_pkg::OFS_CMPA_HI, 16'h1234);
        wr16(ptm_pkg::OFS_CAPB_HI, 16'h5678);
        apb(1'b1, ptm_pkg::OFS_CMPA_LO, 8'h99);
        rd16(ptm_pkg::OFS_CMPA_HI, v);
        chk("a pair", 16'h1234, 16'h1234, v); // buffered low
        rd16(ptm_pkg::OFS_CAPB_HI, v);
        chk("b pair", 16'h5678, 16'h5678, v);
        wr16(ptm_pkg::OFS_CNT_HI, 16'hFFFF);
        rd16(ptm_pkg::OFS_CNT_HI, v);
        chk("counter ro", 0, 0, v); // read only
        wr16(ptm_pkg::OFS_PER_HI, 16'h0000);
        wr16(ptm_pkg::OFS_CMPA_HI, 16'h0008);
        for (int k = 0; k < 16; k++) begin
            code = k[1:0];
            o = k[2];
            run(c1(ptm_pkg::MODE_CMP, code, o, k[3], 1'b0, 1'b0));
            // level lands at enable rise plus one, pin one stage later
            repeat (3) @(posedge clk);
            chk("initial level", o ^ k[3], o ^ k[3], pin);
            repeat (30) @(posedge clk);
            e = (code == 2'h0) ? o : (code == 2'h1) ? 1'b0 :
                (code == 2'h2) ? 1'b1 : ~o;
            chk("match level", e ^ k[3], e ^ k[3], pin);
            chk("a flags", 1, 1, na); // one match
        end
        wr16(ptm_pkg::OFS_PER_HI, 16'h0004);
        pv = pin;
        run(c1(ptm_pkg::MODE_TMR, ptm_pkg::PA_2, 1'b1, 1'b1, 1'b0, 1'b1));
        repeat (45) @(posedge clk);
        chk("timer pin", pv, pv, pin); // pin unused
        chk("p flags off", 0, 0, np); // clear on a
        chk("a flags", 4, 6, na);
        rd16(ptm_pkg::OFS_CNT_HI, v);
        chk("count a", 0, 8, v);
        run(c1(ptm_pkg::MODE_TMR, ptm_pkg::PA_0, 1'b0, 1'b0, 1'b0, 1'b0));
        repeat (45) @(posedge clk);
        chk("a flags off", 0, 0, na); // clear on p
        chk("p flags", 8, 10, np);
        rd16(ptm_pkg::OFS_CNT_HI, v);
        chk("count p", 0, 4, v); // no overflow
        wr16(ptm_pkg::OFS_CMPA_HI, 16'h0003);
        wr16(ptm_pkg::OFS_PER_HI, 16'h0008);
        for (int k = 0; k < 6; k++) begin
            o = k[0];
            code = k[2:1];
            run(c1(ptm_pkg::MODE_PWM, code, o, 1'b0, 1'b0, 1'b1));
            repeat (4) @(posedge clk);
            h = 0;
            // counter runs 0..8: 18 samples span two whole periods
            repeat (18) begin
                @(posedge clk);
                h += (pin === 1'b1);
            end
            v = (code == 2'h0) ? (o ? 0 : 18) :
                (code == 2'h1) ? (o ? 18 : 0) : (o ? 6 : 12);
            chk("pwm high cycles", v, v, h); // duty
        end
        wr16(ptm_pkg::OFS_CMPA_HI, 16'h0008);
        run(c1(ptm_pkg::MODE_PWM, ptm_pkg::PA_3, 1'b1, 1'b0, 1'b0, 1'b0));
        repeat (3) @(posedge clk);
        chk("pulse start", 1, 1, pin); // leading level
        repeat (30) @(posedge clk);
        chk("pulse end", 0, 0, pin); // trailing edge
        apb(1'b0, ptm_pkg::OFS_CTRL0, 8'h00);
        chk("pulse enable", 0, 0, rq); // enable cleared
        wr16(ptm_pkg::OFS_PER_HI, 16'h0000);
        for (int k = 0; k < 7; k++) begin
            code = (k == 4) ? ptm_pkg::PA_2 : k[1:0];
            ps = (k == 5) ? 2'h1 : (k == 6) ? 2'h2 : 2'h0;
            apb(1'b1, ptm_pkg::OFS_CTRL2, (k == 4) ? 8'h02 : 8'h00);
            wr16(ptm_pkg::OFS_CMPA_HI, 16'h0000);
            wr16(ptm_pkg::OFS_CAPB_HI, 16'h0000);
            run(c1(ptm_pkg::MODE_CAP, code, 1'b0, 1'b0, k >= 5, 1'b0));
            // filter select keeps enable high: no counter restart
            if (k == 6)
                apb(1'b1, ptm_pkg::OFS_CTRL0, 8'h09); // filter input
            repeat (20) @(posedge clk);
            i_ptm_pin_model.set_pin(ps, 1'b1);
            repeat (20) @(posedge clk);
            i_ptm_pin_model.set_pin(ps, 1'b0);
            repeat (10) @(posedge clk);
            rd16(ptm_pkg::OFS_CMPA_HI, v);
            case (k)
                0:       chk("cap rise", 20, 30, v);
                1, 2:    chk("cap fall", 40, 52, v);
                3:       chk("cap off", 0, 0, v); // disabled
                4:       chk("cap a clr", 16, 26, v); // cleared
                default: chk("cap ext", 40, 52, v); // clock pin, filter pin for k 6
            endcase
            rd16(ptm_pkg::OFS_CAPB_HI, v);
            chk("cap b", (k == 4) ? 20 : 0, (k == 4) ? 30 : 0, v);
            apb(1'b0, ptm_pkg::OFS_CTRL2, 8'h00);
            chk("edge flag", (k == 4) ? 2 : 0, (k == 4) ? 2 : 1, rq);
            i_ptm_pin_model.set_pin(2'h0, 1'b0);
            i_ptm_pin_model.set_pin(2'h1, 1'b0);
        end
        test_done();
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        test_done();
    end
endmodule

//--- tb/ptm_pin_model.sv
// ptm_pin_model: levels on the capture, clock and filter pins of the timer
// assumes the bench calls set_pin from its main sequence, clocked by clk
`timescale 1ns/100ps
module ptm_pin_model (
    input  wire logic clk,
    output logic      cap_pin,
    output logic      ext_pin,
    output logic      flt_pin
);
    // ------------------------------------------------------------------
    // pin levels
    // ------------------------------------------------------------------
    initial begin
        cap_pin = 1'b0;
        ext_pin = 1'b0;
        flt_pin = 1'b0;
    end

    // pins are plain logic levels that hold between calls; a change lands
    // just after an edge, which the design must still synchronise
    task automatic set_pin(input logic [1:0] sel, input logic lvl);
        @(posedge clk);
        case (sel)
            2'h0:    cap_pin <= lvl;
            2'h1:    ext_pin <= lvl;
            default: flt_pin <= lvl;
        endcase
    endtask
endmodule
